// *** rtl/network_card_host_command_interface.sv ***
// Function
// - card holds a 4K dual ported memory reachable by host and controller.
// - host reaches card memory through memory mapped function locations.
// - data mover supports six directions among controller, memory and link.
// - host issues commands and exchanges message data both ways.
// - each received vector address is kept in 128 byte working memory.
// - every command vector carries the address of its result record.
// - card writes command status into the record the vector names.
// - one message sent at a time; up to four received per command.
// - card interrupts host once the vector address is validated.
// - card interrupts host again when command execution finishes.
// - link controller serializes, inserts zeros, frames, adds crc, buffers bytes.
// - controller runs fixed firmware and controls all card functions.
// - host presets status byte FF; card changes it and interrupts.
// - 12 bit vector address arrives one byte at a time with polling.
// - ready high accepts byte; strobe drops ready; ready returns after strobe.
`timescale 1ns/1ps
module network_card_host_command_interface (
  input  wire logic                      clk_sys,
  input  wire logic                      reset,
  input  wire logic                      ce,
  input  wire netcard_pkg::host_bus_type host_bus,
  output logic      [7:0]                host_data_lines_out,
  output logic                           host_data_lines_oe,
  input  wire logic                      irq_ack,
  output logic                           host_irq,
  input  wire logic                      line_rx,
  output logic                           line_tx,
  output logic                           line_tx_en
);
  import netcard_pkg::*;

  typedef enum {S_ADDR_LO, S_ADDR_HI, S_CHECK, S_FETCH, S_DECODE,
                S_XFER, S_STATUS, S_DONE} state_type;

  state_type     state_reg;
  dma_dir_type   dir_reg;
  host_bus_type  hb1_reg, hb2_reg;
  link_byte_type tx_in, rx_out;
  logic [7:0]    work_mem [WORK_BYTES];
  logic [11:0]   hcnt_reg, ptr_reg, vec, res_addr, buf_addr, b_addr;
  logic [7:0]    hout_reg, strobe_byte_reg, mcu_byte_reg, left_reg, stat_reg;
  logic [7:0]    a_q, b_q, b_wdata;
  logic [2:0]    idx_reg, msg_left_reg, recv_n;
  logic          ready_reg, pend_reg, acc_prev_reg, ack1_reg, ack2_reg, ack_prev_reg;
  logic          acc_pend_reg, done_pend_reg, rd_pend_reg, have_reg;
  logic          acc_now, take, take_rd, take_wr, ack_rise, a_we, b_we, tx_ready, rx_end;

  // access decode on the synchronised host bus
  assign acc_now  = hb2_reg.cs & (hb2_reg.rd | hb2_reg.wr);
  assign take     = acc_now & ~acc_prev_reg;
  assign take_rd  = take & hb2_reg.rd;
  assign take_wr  = take & hb2_reg.wr & ~hb2_reg.rd;
  assign a_we     = take_wr & (hb2_reg.func == FN_DATA_INC);
  assign ack_rise = ack2_reg & ~ack_prev_reg;
  assign host_irq = acc_pend_reg | done_pend_reg;
  assign host_data_lines_out = hout_reg;
  assign host_data_lines_oe  = hb2_reg.cs & hb2_reg.rd;

  // vector fields kept in working memory
  assign vec      = {work_mem[WM_ADDR_HI][3:0], work_mem[WM_ADDR_LO]};
  assign res_addr = {work_mem[WM_RES_HI][3:0], work_mem[WM_RES_LO]};
  assign buf_addr = {work_mem[WM_BUF_HI][3:0], work_mem[WM_BUF_LO]};
  assign recv_n   = (work_mem[WM_COUNT] == 8'h00) ? 3'h1 :
                    (work_mem[WM_COUNT] > 8'(MAX_RECV)) ? MAX_RECV :
                    work_mem[WM_COUNT][2:0];

  // controller port of the shared memory
  always_comb begin
    b_addr  = ptr_reg;
    b_we    = 1'b0;
    b_wdata = rx_out.data;
    if (state_reg == S_FETCH) begin
      b_addr = vec + {9'h000, idx_reg};
    end else if (state_reg == S_STATUS) begin
      b_addr  = res_addr;
      b_we    = (dir_reg == DIR_MCU_RAM);
      b_wdata = stat_reg;
    end else if (state_reg == S_XFER && dir_reg == DIR_LINK_RAM) begin
      b_we = rx_out.valid;
    end
  end

  // transmit feed from controller byte or memory
  always_comb begin
    tx_in = '0;
    if (state_reg == S_XFER && dir_reg == DIR_MCU_LINK) begin
      tx_in.valid = 1'b1;
      tx_in.data  = mcu_byte_reg;
    end else if (state_reg == S_XFER && dir_reg == DIR_RAM_LINK) begin
      tx_in.valid = have_reg;
      tx_in.data  = mcu_byte_reg;
      tx_in.last  = (left_reg == 8'h01);
    end
  end

  shared_ram shared_ram_inst (
    .clk_sys (clk_sys),
    .ce      (ce),
    .a_addr  (hcnt_reg),
    .a_we    (a_we),
    .a_wdata (hb2_reg.data),
    .a_rdata (a_q),
    .b_addr  (b_addr),
    .b_we    (b_we),
    .b_wdata (b_wdata),
    .b_rdata (b_q)
  );

  serial_link_controller serial_link_controller_inst (
    .clk_sys    (clk_sys),
    .reset      (reset),
    .ce         (ce),
    .tx_in      (tx_in),
    .tx_ready   (tx_ready),
    .rx_out     (rx_out),
    .rx_end     (rx_end),
    .line_rx    (line_rx),
    .line_tx    (line_tx),
    .line_tx_en (line_tx_en)
  );

  // two stage synchronisers for host pins
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      hb1_reg <= '0; hb2_reg <= '0; acc_prev_reg <= 1'b0;
      ack1_reg <= 1'b0; ack2_reg <= 1'b0; ack_prev_reg <= 1'b0;
    end else if (ce) begin
      hb1_reg <= host_bus; hb2_reg <= hb1_reg; acc_prev_reg <= acc_now;
      ack1_reg <= irq_ack; ack2_reg <= ack1_reg; ack_prev_reg <= ack2_reg;
    end
  end

  // host functions: memory counter, data, counter and status reads
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      hcnt_reg <= 12'h000; hout_reg <= 8'h00;
    end else if (ce) begin
      if (take_rd) begin
        case (hb2_reg.func)
          FN_DATA_INC: begin hout_reg <= a_q; hcnt_reg <= hcnt_reg + 12'h001; end
          FN_STROBE:   hout_reg <= a_q;
          FN_CNT_LO:   hout_reg <= hcnt_reg[7:0];
          FN_CNT_HI:   hout_reg <= {4'h0, hcnt_reg[11:8]};
          FN_STATUS:   hout_reg <= 8'(ready_reg) << READY_BIT;
          default:     hout_reg <= 8'h00;
        endcase
      end else if (take_wr) begin
        case (hb2_reg.func)
          FN_DATA_INC: hcnt_reg <= hcnt_reg + 12'h001;
          FN_CNT_LO:   hcnt_reg[7:0] <= hb2_reg.data;
          FN_CNT_HI:   hcnt_reg[11:8] <= hb2_reg.data[3:0];
          default:     hcnt_reg <= hcnt_reg;
        endcase
      end
    end
  end

  // ready and strobe handshake for vector address bytes
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ready_reg <= 1'b0; pend_reg <= 1'b0; strobe_byte_reg <= 8'h00;
    end else if (ce) begin
      if (take_wr && hb2_reg.func == FN_STROBE && ready_reg) begin
        ready_reg <= 1'b0;
        pend_reg  <= 1'b1;
        strobe_byte_reg <= hb2_reg.data;
      end else begin
        if (pend_reg && (state_reg == S_ADDR_LO || state_reg == S_ADDR_HI))
          pend_reg <= 1'b0;
        else if (!pend_reg && !acc_now &&
                 (state_reg == S_ADDR_LO || state_reg == S_ADDR_HI))
          ready_reg <= 1'b1;
      end
    end
  end

  // interrupt requests, set wins over acknowledge
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      acc_pend_reg <= 1'b0; done_pend_reg <= 1'b0;
    end else if (ce) begin
      if (state_reg == S_CHECK && vec <= VEC_LAST) acc_pend_reg <= 1'b1;
      else if (ack_rise) acc_pend_reg <= 1'b0;
      if (state_reg == S_DONE) done_pend_reg <= 1'b1;
      else if (ack_rise) done_pend_reg <= 1'b0;
    end
  end

  // working memory capture of address bytes and vector fields
  always_ff @(posedge clk_sys) begin
    if (ce) begin
      if (state_reg == S_ADDR_LO && pend_reg) work_mem[WM_ADDR_LO] <= strobe_byte_reg;
      if (state_reg == S_ADDR_HI && pend_reg) work_mem[WM_ADDR_HI] <= strobe_byte_reg;
      if (state_reg == S_FETCH && rd_pend_reg) work_mem[WM_CODE + int'(idx_reg)] <= b_q;
    end
  end

  // command sequencer and data mover
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_reg <= S_ADDR_LO; dir_reg <= DIR_RAM_MCU; idx_reg <= 3'h0;
      ptr_reg <= 12'h000; left_reg <= 8'h00; mcu_byte_reg <= 8'h00;
      stat_reg <= STAT_OK; msg_left_reg <= 3'h0; rd_pend_reg <= 1'b0; have_reg <= 1'b0;
    end else if (ce) begin
      case (state_reg)
        S_ADDR_LO: if (pend_reg) state_reg <= S_ADDR_HI;
        S_ADDR_HI: if (pend_reg) state_reg <= S_CHECK;
        S_CHECK: begin
          idx_reg <= 3'h0; dir_reg <= DIR_RAM_MCU; rd_pend_reg <= 1'b0;
          state_reg <= (vec <= VEC_LAST) ? S_FETCH : S_ADDR_LO;
        end
        S_FETCH: begin
          rd_pend_reg <= ~rd_pend_reg;
          if (rd_pend_reg) begin
            idx_reg <= idx_reg + 3'h1;
            if (idx_reg == VEC_FIELDS - 3'h1) state_reg <= S_DECODE;
          end
        end
        S_DECODE: begin
          ptr_reg <= buf_addr; have_reg <= 1'b0; rd_pend_reg <= 1'b0;
          left_reg <= work_mem[WM_COUNT]; mcu_byte_reg <= work_mem[WM_COUNT];
          msg_left_reg <= recv_n;
          if (work_mem[WM_CODE] == CMD_SEND && work_mem[WM_COUNT] != 8'h00) begin
            dir_reg <= DIR_MCU_LINK; state_reg <= S_XFER;
          end else if (work_mem[WM_CODE] == CMD_RECV) begin
            dir_reg <= DIR_LINK_MCU; state_reg <= S_XFER;
          end else begin
            stat_reg <= (work_mem[WM_CODE] == CMD_SEND) ? STAT_OK : STAT_BAD_CMD;
            dir_reg  <= DIR_MCU_RAM; state_reg <= S_STATUS;
          end
        end
        S_XFER: begin
          case (dir_reg)
            DIR_MCU_LINK: if (tx_ready) dir_reg <= DIR_RAM_LINK;
            DIR_RAM_LINK: begin
              if (!have_reg) begin
                rd_pend_reg <= ~rd_pend_reg;
                if (rd_pend_reg) begin mcu_byte_reg <= b_q; have_reg <= 1'b1; end
              end else if (tx_ready) begin
                have_reg <= 1'b0; ptr_reg <= ptr_reg + 12'h001;
                left_reg <= left_reg - 8'h01;
                if (left_reg == 8'h01) begin
                  stat_reg <= STAT_OK; dir_reg <= DIR_MCU_RAM; state_reg <= S_STATUS;
                end
              end
            end
            DIR_LINK_MCU: if (rx_out.valid) begin
              mcu_byte_reg <= rx_out.data; dir_reg <= DIR_LINK_RAM;
            end
            DIR_LINK_RAM: begin
              if (rx_out.valid) ptr_reg <= ptr_reg + 12'h001;
              if (rx_end) begin
                msg_left_reg <= msg_left_reg - 3'h1;
                if (msg_left_reg == 3'h1) begin
                  stat_reg <= STAT_OK; dir_reg <= DIR_MCU_RAM; state_reg <= S_STATUS;
                end else dir_reg <= DIR_LINK_MCU;
              end
            end
            default: begin dir_reg <= DIR_MCU_RAM; state_reg <= S_STATUS; end
          endcase
        end
        S_STATUS: state_reg <= S_DONE;
        S_DONE:   state_reg <= S_ADDR_LO;
        default:  state_reg <= S_ADDR_LO;
      endcase
    end
  end

  // checks on the handshake, interrupts, status write, address capture, receive count and memory counter
  ready_drop_a: assert property (@(posedge clk_sys) disable iff (reset)
    (ce && take_wr && hb2_reg.func == FN_STROBE) |=> !ready_reg)
    else $error("ready stayed high after strobe");
  ready_wait_a: assert property (@(posedge clk_sys) disable iff (reset)
    (ce && !ready_reg && acc_now) |=> !$rose(ready_reg) || !ce)
    else $error("ready rose during strobe");
  irq_hold_a: assert property (@(posedge clk_sys) disable iff (reset)
    (ce && host_irq && !ack_rise) |=> host_irq)
    else $error("interrupt dropped without acknowledge");
  accept_irq_a: assert property (@(posedge clk_sys) disable iff (reset)
    (ce && state_reg == S_CHECK && vec <= VEC_LAST) |=> acc_pend_reg ##1 state_reg == S_FETCH)
    else $error("validated vector gave no accept interrupt");
  done_irq_a: assert property (@(posedge clk_sys) disable iff (reset)
    (ce && state_reg == S_STATUS) |=> state_reg == S_DONE ##1 done_pend_reg)
    else $error("completion gave no interrupt");
  status_write_a: assert property (@(posedge clk_sys) disable iff (reset)
    (b_we && state_reg == S_STATUS) |-> (b_addr == res_addr && b_wdata != STAT_BUSY))
    else $error("status write wrong address or busy value");
  addr_keep_a: assert property (@(posedge clk_sys) disable iff (reset)
    (ce && state_reg == S_ADDR_HI && pend_reg)
    |=> work_mem[WM_ADDR_HI] == $past(strobe_byte_reg))
    else $error("vector address byte not kept");
  recv_limit_a: assert property (@(posedge clk_sys) disable iff (reset)
    (msg_left_reg <= MAX_RECV))
    else $error("receive count above limit");
  cnt_inc_a: assert property (@(posedge clk_sys) disable iff (reset)
    (ce && take && hb2_reg.func == FN_DATA_INC) |=> hcnt_reg == $past(hcnt_reg) + 12'h001)
    else $error("memory counter did not advance");

  send_cov_c: cover property (@(posedge clk_sys) disable iff (reset)
    state_reg == S_XFER && dir_reg == DIR_RAM_LINK && tx_ready);
  recv_cov_c: cover property (@(posedge clk_sys) disable iff (reset)
    state_reg == S_XFER && rx_end && msg_left_reg == 3'h1);
  bad_cov_c: cover property (@(posedge clk_sys) disable iff (reset)
    state_reg == S_STATUS && stat_reg == STAT_BAD_CMD);
endmodule // network_card_host_command_interface

// *** rtl/netcard_pkg.sv ***
package netcard_pkg;
  // shared memory and working memory sizes
  localparam int RAM_AW       = 12;
  localparam int RAM_BYTES    = 4096;
  localparam int WORK_BYTES   = 128;
  // host function offsets
  localparam logic [2:0] FN_DATA_INC = 3'h0;
  localparam logic [2:0] FN_STROBE   = 3'h1;
  localparam logic [2:0] FN_CNT_LO   = 3'h2;
  localparam logic [2:0] FN_CNT_HI   = 3'h3;
  localparam logic [2:0] FN_STATUS   = 3'h7;
  localparam int         READY_BIT   = 3;
  // command vector layout, byte offsets in working memory
  localparam logic [2:0]  VEC_FIELDS  = 3'h6;
  localparam logic [11:0] VEC_LAST    = 12'h0FFA;
  localparam int          WM_ADDR_LO  = 0;
  localparam int          WM_ADDR_HI  = 1;
  localparam int          WM_CODE     = 2;
  localparam int          WM_RES_LO   = 3;
  localparam int          WM_RES_HI   = 4;
  localparam int          WM_COUNT    = 5;
  localparam int          WM_BUF_LO   = 6;
  localparam int          WM_BUF_HI   = 7;
  // command codes and result status values
  localparam logic [7:0] CMD_SEND     = 8'h01;
  localparam logic [7:0] CMD_RECV     = 8'h02;
  localparam logic [7:0] STAT_BUSY    = 8'hFF;
  localparam logic [7:0] STAT_OK      = 8'h00;
  localparam logic [7:0] STAT_BAD_CMD = 8'h01;
  localparam logic [2:0] MAX_RECV     = 3'h4;
  // serial link framing
  localparam logic [7:0]  FLAG        = 8'h7E;
  localparam logic [15:0] CRC_INIT    = 16'hFFFF;
  localparam logic [15:0] CRC_POLY    = 16'h1021;
  localparam logic [2:0]  STUFF_ONES  = 3'h5;
  localparam logic [2:0]  ABORT_ONES  = 3'h7;
  localparam int          CLK_NS      = 20;
  localparam int          BIT_NS      = 1000;
  localparam int          BIT_CYCLES  = BIT_NS / CLK_NS;

  typedef enum {DIR_MCU_LINK, DIR_LINK_MCU, DIR_RAM_MCU,
                DIR_MCU_RAM, DIR_RAM_LINK, DIR_LINK_RAM} dma_dir_type;

  typedef struct packed {
    logic       cs;
    logic       rd;
    logic       wr;
    logic [2:0] func;
    logic [7:0] data;
  } host_bus_type;

  typedef struct packed {
    logic       valid;
    logic       last;
    logic [7:0] data;
  } link_byte_type;
endpackage

// *** rtl/shared_ram.sv ***
`timescale 1ns/1ps
module shared_ram (
  input  wire logic                        clk_sys,
  input  wire logic                        ce,
  input  wire logic [netcard_pkg::RAM_AW-1:0] a_addr,
  input  wire logic                        a_we,
  input  wire logic [7:0]                  a_wdata,
  output logic      [7:0]                  a_rdata,
  input  wire logic [netcard_pkg::RAM_AW-1:0] b_addr,
  input  wire logic                        b_we,
  input  wire logic [7:0]                  b_wdata,
  output logic      [7:0]                  b_rdata
);
  import netcard_pkg::*;

  logic [7:0] mem [RAM_BYTES];

  // host port, read returns old data on a write
  always_ff @(posedge clk_sys) begin
    if (ce) begin
      if (a_we) mem[a_addr] <= a_wdata;
      a_rdata <= mem[a_addr];
    end
  end

  // controller port
  always_ff @(posedge clk_sys) begin
    if (ce) begin
      if (b_we) mem[b_addr] <= b_wdata;
      b_rdata <= mem[b_addr];
    end
  end
endmodule // shared_ram

// *** rtl/serial_link_controller.sv ***
`timescale 1ns/1ps
module serial_link_controller (
  input  wire logic                       clk_sys,
  input  wire logic                       reset,
  input  wire logic                       ce,
  input  wire netcard_pkg::link_byte_type tx_in,
  output logic                            tx_ready,
  output netcard_pkg::link_byte_type      rx_out,
  output logic                            rx_end,
  input  wire logic                       line_rx,
  output logic                            line_tx,
  output logic                            line_tx_en
);
  import netcard_pkg::*;

  typedef enum {TX_IDLE, TX_OPEN, TX_DATA, TX_CRC, TX_CLOSE} tx_phase_type;

  tx_phase_type tph_reg;
  logic [15:0]  tsh_reg, crc_reg;
  logic [3:0]   tcnt_reg;
  logic [2:0]   tones_reg, rones_reg;
  logic         tlast_reg, rx1_reg, rx2_reg, in_frame_reg, got_reg;
  logic [7:0]   div_reg, rwin_reg, rbyte_reg;
  logic [2:0]   rcnt_reg;
  logic         tick, stuff_now, tbit, rbit, flag_now, crc_fb;

  assign tick      = (div_reg == 8'h00);
  assign stuff_now = (tones_reg == STUFF_ONES);
  assign tbit      = tsh_reg[0];
  assign crc_fb    = crc_reg[15] ^ tbit;
  assign tx_ready  = (tph_reg == TX_IDLE) | ((tph_reg == TX_DATA) & tick & ~stuff_now
                     & (tcnt_reg == 4'h7) & ~tlast_reg);
  assign rbit      = rx2_reg;
  assign flag_now  = ({rbit, rwin_reg[7:1]} == FLAG);

  // bit rate divider
  always_ff @(posedge clk_sys) begin
    if (reset) div_reg <= 8'h00;
    else if (ce) div_reg <= tick ? 8'(BIT_CYCLES - 1) : div_reg - 8'h01;
  end

  // transmit: framing, zero insertion, crc, serialization
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      tph_reg <= TX_IDLE; tsh_reg <= 16'h0000; tcnt_reg <= 4'h0; tones_reg <= 3'h0;
      tlast_reg <= 1'b0; crc_reg <= CRC_INIT; line_tx <= 1'b1; line_tx_en <= 1'b0;
    end else if (ce) begin
      if (tph_reg == TX_IDLE) begin
        // last closing flag bit keeps its full bit time
        if (tick) begin
          line_tx_en <= 1'b0;
          line_tx    <= 1'b1;
        end
        if (tx_in.valid) begin
          tph_reg   <= TX_OPEN;
          tsh_reg   <= {tx_in.data, FLAG};
          tlast_reg <= tx_in.last;
          tcnt_reg  <= 4'h0;
        end
      end else if (tick) begin
        line_tx_en <= 1'b1;
        if ((tph_reg == TX_DATA || tph_reg == TX_CRC ||
             (tph_reg == TX_CLOSE && tcnt_reg == 4'h0)) && stuff_now) begin
          line_tx   <= 1'b0;
          tones_reg <= 3'h0;
        end else begin
          line_tx  <= tbit;
          tsh_reg  <= {1'b0, tsh_reg[15:1]};
          tcnt_reg <= tcnt_reg + 4'h1;
          if (tph_reg != TX_OPEN && tph_reg != TX_CLOSE)
            tones_reg <= tbit ? tones_reg + 3'h1 : 3'h0;
          if (tph_reg == TX_DATA)
            crc_reg <= {crc_reg[14:0], 1'b0} ^ (crc_fb ? CRC_POLY : 16'h0000);
          case (tph_reg)
            TX_OPEN: if (tcnt_reg == 4'h7) begin
              tph_reg <= TX_DATA; tsh_reg <= {8'h00, tsh_reg[8:1]};
              tcnt_reg <= 4'h0; tones_reg <= 3'h0; crc_reg <= CRC_INIT;
            end
            TX_DATA: if (tcnt_reg == 4'h7) begin
              tcnt_reg <= 4'h0;
              if (!tlast_reg && tx_in.valid) begin
                tsh_reg   <= {8'h00, tx_in.data};
                tlast_reg <= tx_in.last;
              end else begin
                tph_reg <= TX_CRC;
                tsh_reg <= ~({crc_reg[14:0], 1'b0} ^ (crc_fb ? CRC_POLY : 16'h0000));
              end
            end
            TX_CRC: if (tcnt_reg == 4'hF) begin
              tph_reg <= TX_CLOSE; tsh_reg <= {8'h00, FLAG}; tcnt_reg <= 4'h0;
            end
            TX_CLOSE: if (tcnt_reg == 4'h7) tph_reg <= TX_IDLE;
            default: tph_reg <= TX_IDLE;
          endcase
        end
      end
    end
  end

  // receive: line sync, flag hunt, zero deletion, byte assembly
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rx1_reg <= 1'b1; rx2_reg <= 1'b1; rwin_reg <= 8'h00; rbyte_reg <= 8'h00;
      rcnt_reg <= 3'h0; rones_reg <= 3'h0; in_frame_reg <= 1'b0; got_reg <= 1'b0;
      rx_out <= '0; rx_end <= 1'b0;
    end else if (ce) begin
      rx1_reg <= line_rx;
      rx2_reg <= rx1_reg;
      rx_out.valid <= 1'b0;
      rx_end <= 1'b0;
      if (tick) begin
        rwin_reg <= {rbit, rwin_reg[7:1]};
        if (rbit && rones_reg != ABORT_ONES) rones_reg <= rones_reg + 3'h1;
        else if (!rbit) rones_reg <= 3'h0;
        if (flag_now) begin
          rx_end <= in_frame_reg & got_reg;
          in_frame_reg <= 1'b1; got_reg <= 1'b0; rcnt_reg <= 3'h0;
        end else if (rbit && rones_reg >= 3'h6) begin
          in_frame_reg <= 1'b0;
        end else if (!(!rbit && rones_reg == STUFF_ONES)) begin
          rbyte_reg <= {rbit, rbyte_reg[7:1]};
          rcnt_reg  <= rcnt_reg + 3'h1;
          if (rcnt_reg == 3'h7 && in_frame_reg) begin
            rx_out.valid <= 1'b1;
            rx_out.data  <= {rbit, rbyte_reg[7:1]};
            got_reg      <= 1'b1;
          end
        end
      end
    end
  end
endmodule // serial_link_controller

// *** tb/host_model.sv ***
`timescale 1ns/1ps
module host_model (
  input  wire logic                  clk_sys,
  output netcard_pkg::host_bus_type  host_bus,
  input  wire logic [7:0]            rdata,
  input  wire logic                  oe
);
  import netcard_pkg::*;
  initial host_bus = '0;
  // one access held for five cycles, lines scrambled on release
  task automatic access(input logic rd, input logic [2:0] fn, input logic [7:0] d,
                        output logic [7:0] q);
    @(posedge clk_sys) host_bus <= '{1'b1, rd, !rd, fn, d};
    repeat (5) @(posedge clk_sys);
    q = oe ? rdata : 8'hxx; // data counts only while the card drives it
    host_bus <= '{1'b0, 1'b0, 1'b0, fn, ~d};
    repeat (3) @(posedge clk_sys);
  endtask
  // vector address in two bytes, ready polled before each
  task automatic send_vec(input logic [11:0] a);
    logic [7:0] q;
    for (int i = 0; i < 2; i++) begin
      q = 8'h00;
      while (q[READY_BIT] !== 1'b1) access(1'b1, FN_STATUS, 8'h00, q);
      access(1'b0, FN_STROBE, i ? {4'h0, a[11:8]} : a[7:0], q);
    end
  endtask
endmodule // host_model

// *** tb/network_card_host_command_interface_tb.sv ***
`timescale 1ns/1ps
module network_card_host_command_interface_tb;
  import netcard_pkg::*;
  `define CHECK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin errors++; \
    $display("mismatch %s expected %h seen %h", nm, e, g); end end
  logic clk_sys, reset, irq_ack, host_irq, oe, line_tx, line_tx_en;
  logic [7:0] hout, q;
  host_bus_type host_bus;
  int errors = 0, n_tests = 0, cycles = 0;
  logic line_rx = 1'b1;
  logic [7:0] win;
  logic [7:0] got [8];
  int n_got = 0, nb = 0, ones = 0, frames = 0, run1 = 0;
  // far station receiver: mid bit samples, zero deletion, byte assembly
  always @(posedge line_tx_en) begin
    n_got = 0;
    nb = 0;
    ones = 0;
    repeat (BIT_CYCLES / 2) @(posedge clk_sys);
    while (line_tx_en) begin
      if (ones != 5 || line_tx) begin
        win = {line_tx, win[7:1]};
        nb++;
        if (nb == 8) begin
          if (n_got < 8) got[n_got] = win;
          n_got++;
          nb = 0;
        end
      end
      ones = line_tx ? ones + 1 : 0;
      repeat (BIT_CYCLES) @(posedge clk_sys);
    end
    frames++;
  end
  // far station transmitter, zero inserted after five ones
  task automatic put_byte(input logic [7:0] b, input logic raw);
    for (int i = 0; i < 8; i++) begin
      line_rx <= b[i];
      repeat (BIT_CYCLES) @(posedge clk_sys);
      run1 = (b[i] && !raw) ? run1 + 1 : 0;
      if (run1 == 5) begin
        line_rx <= 1'b0;
        repeat (BIT_CYCLES) @(posedge clk_sys);
        run1 = 0;
      end
    end
  endtask
  network_card_host_command_interface network_card_host_command_interface_inst (
    .clk_sys(clk_sys), .reset(reset), .ce(1'b1), .host_bus(host_bus),
    .host_data_lines_out(hout), .host_data_lines_oe(oe), .irq_ack(irq_ack),
    .host_irq(host_irq), .line_rx(line_rx), .line_tx(line_tx), .line_tx_en(line_tx_en));
  host_model host_model_inst (.clk_sys(clk_sys), .host_bus(host_bus), .rdata(hout),
    .oe(oe));
  initial begin
    clk_sys = 0;
    forever #10 clk_sys = ~clk_sys;
  end
  task automatic end_of_test;
    $display("errors %0d n_tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // hang guard
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 60000) begin
      errors++;
      end_of_test();
    end
  end
  function automatic logic [7:0] exp_status(input logic [7:0] c);
    return (c == CMD_SEND || c == CMD_RECV) ? STAT_OK : STAT_BAD_CMD;
  endfunction
  task automatic poke(input logic [11:0] a, input logic [7:0] d);
    host_model_inst.access(1'b0, FN_CNT_LO, a[7:0], q);
    host_model_inst.access(1'b0, FN_CNT_HI, {4'h0, a[11:8]}, q);
    host_model_inst.access(1'b0, FN_DATA_INC, d, q);
  endtask
  task automatic peek(input logic [11:0] a, output logic [7:0] d);
    host_model_inst.access(1'b0, FN_CNT_LO, a[7:0], q);
    host_model_inst.access(1'b0, FN_CNT_HI, {4'h0, a[11:8]}, q);
    host_model_inst.access(1'b1, FN_STROBE, 8'h00, d);
  endtask
  // vector and preset result first, then the address
  task automatic run_cmd(input logic [11:0] v, input logic [7:0] code, input logic [7:0] n);
    logic [11:0] r;
    logic [7:0]  s;
    r = 12'h800;
    poke(v, code);
    poke(v + 12'h001, r[7:0]);
    poke(v + 12'h002, {4'h0, r[11:8]});
    poke(v + 12'h003, n);
    poke(v + 12'h004, 8'h00);
    poke(v + 12'h005, 8'h09);
    poke(r, STAT_BUSY);
    host_model_inst.send_vec(v);
    s = 8'h00;
    for (int i = 0; i < 2000 && s[READY_BIT] !== 1'b1; i++)
      host_model_inst.access(1'b1, FN_STATUS, 8'h00, s);
    repeat (20) @(posedge clk_sys);
    `CHECK("irq", v <= VEC_LAST, host_irq)
    peek(r, s);
    `CHECK("status", (v <= VEC_LAST) ? exp_status(code) : STAT_BUSY, s)
    irq_ack <= 1'b1;
    repeat (4) @(posedge clk_sys);
    irq_ack <= 1'b0;
    repeat (3) @(posedge clk_sys);
    `CHECK("irq_clr", 1'b0, host_irq)
  endtask
  initial begin
    logic [11:0] a;
    logic [7:0]  d, g;
    logic [7:0]  tx [3];
    reset = 1'b1;
    irq_ack = 1'b0;
    void'($urandom(32'h5ad886e5));
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    // random shared memory traffic, corners first
    for (int i = 0; i < 6; i++) begin
      a = (i == 0) ? 12'h000 : (i == 1) ? 12'hFFF : 12'($urandom % 4096);
      d = 8'($urandom);
      poke(a, d);
      peek(a, g);
      `CHECK("ram", d, g)
    end
    run_cmd(12'($urandom % 12'h700), CMD_SEND, 8'h00);
    for (int i = 0; i < 3; i++) begin
      tx[i] = 8'($urandom);
      poke(12'h900 + 12'(i), tx[i]);
    end
    run_cmd(12'($urandom % 12'h700), CMD_SEND, 8'h03);
    wait (frames == 1);
    `CHECK("frame_len", 8, n_got)
    `CHECK("open_flag", FLAG, got[0])
    `CHECK("header", 8'h03, got[1])
    for (int i = 0; i < 3; i++) `CHECK("payload", tx[i], got[i + 2])
    `CHECK("close_flag", FLAG, got[7])
    fork
      run_cmd(12'h100, CMD_RECV, 8'h00);
      begin
        @(posedge host_irq);
        @(posedge clk_sys);
        put_byte(FLAG, 1'b1);
        for (int i = 0; i < 3; i++) put_byte(~tx[i], 1'b0);
        put_byte(FLAG, 1'b1);
        line_rx <= 1'b1;
      end
    join
    for (int i = 1; i < 3; i++) begin
      peek(12'h8FF + 12'(i), g);
      `CHECK("rx_data", ~tx[i], g)
    end
    run_cmd(VEC_LAST, 8'h03 + 8'($urandom % 200), 8'h00);
    run_cmd(VEC_LAST + 12'h001, CMD_SEND, 8'h00);
    end_of_test();
  end
endmodule // network_card_host_command_interface_tb
